/* bench/bot_checker_properties.sv */
// Purpose: port properties of the bulk-only framer
// Assumes: nrst synchronous, active low
// Notes:   bound to the framer at the foot
`timescale 1ns/100ps
module bot_checker (
  input wire       clk,
  input wire       nrst,
  input wire [7:0] protocolCode,
  input wire       ctrlReqValid,
  input wire [7:0] ctrlReqCode,
  input wire       ctrlRespValid,
  input wire [7:0] ctrlRespData,
  input wire       outValid,
  input wire       outLast,
  input wire       outReady,
  input wire       cmdValid,
  input wire [7:0] cmdLun,
  input wire [7:0] inData,
  input wire       inValid,
  input wire       inLast,
  input wire       inReady
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_proto; protocolCode == 8'h50; endproperty
  a_proto: assert property (p_proto)
    else $error("protocol code");
  property p_maxLun; ctrlReqValid && ctrlReqCode == 8'hfe |=> ctrlRespValid && !ctrlRespData; endproperty
  a_maxLun: assert property (p_maxLun)
    else $error("unit answer");
  property p_respCause; ctrlRespValid |-> $past(ctrlReqValid) && $past(ctrlReqCode) == 8'hfe; endproperty
  a_respCause: assert property (p_respCause)
    else $error("stray answer");
  property p_clear; ctrlReqValid && ctrlReqCode == 8'hff |=> outReady && !inValid && !cmdValid; endproperty
  a_clear: assert property (p_clear)
    else $error("reset request");
  property p_cmdLast; cmdValid |-> $past(outValid) && $past(outReady) && $past(outLast); endproperty
  a_cmdLast: assert property (p_cmdLast)
    else $error("command timing");
  property p_lun; cmdValid |-> cmdLun[7:4] == 4'h0; endproperty
  a_lun: assert property (p_lun)
    else $error("unit number");
  property p_status; inLast |-> inValid && inData <= 8'h02; endproperty
  a_status: assert property (p_status)
    else $error("status byte");
  // Host may stall any byte; the byte offered must not move under it
  property p_hold; inValid && !inReady |=> inValid && $stable(inData); endproperty
  a_hold: assert property (p_hold)
    else $error("bulk-in hold");
endmodule
bind bulk_only_storage_transport bot_checker i_chk (
  .clk(clk), .nrst(nrst), .protocolCode(protocolCode), .ctrlReqValid(ctrlReqValid),
  .ctrlReqCode(ctrlReqCode), .ctrlRespValid(ctrlRespValid), .ctrlRespData(ctrlRespData),
  .outValid(outValid), .outLast(outLast), .outReady(outReady), .cmdValid(cmdValid),
  .cmdLun(cmdLun), .inData(inData), .inValid(inValid), .inLast(inLast), .inReady(inReady)
);

/* bench/bulk_only_storage_transport_tb.sv */
// Purpose: self-checking bench for the bulk-only framer
// Assumes: host model on the bulk pipes; bench plays the engine
// Notes:   expected bytes follow the wrapper layouts
`timescale 1ns/100ps
module bulk_only_storage_transport_tb;
  // ****
  // Signals and instances
  // ****
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ctrlReqValid = 1'b0;
  logic [7:0]   ctrlReqCode = 8'h00;
  logic         rxReady = 1'b0;
  logic [7:0]   txData = 8'h00;
  logic         txValid = 1'b0;
  logic         cmdDone = 1'b0;
  logic         cmdFailed = 1'b0;
  wire  [7:0]   outData, inData, protocolCode, ctrlRespData, cmdLun, rxData;
  wire          outValid, outLast, outReady, inValid, inLast, inReady;
  wire          ctrlRespValid, cmdValid, cmdDirIn, rxValid, txReady;
  wire  [127:0] cmdBlock;
  wire  [4:0]   cmdBlockLen;
  wire  [31:0]  cmdLength;
  int           n_mismatch = 0;
  int           compares = 0;
  int           nCmd = 0;
  bulk_only_storage_transport i_dut (
    .clk(clk), .nrst(nrst), .protocolCode(protocolCode), .outData(outData),
    .outValid(outValid), .outLast(outLast), .outReady(outReady), .inData(inData),
    .inValid(inValid), .inLast(inLast), .inReady(inReady), .ctrlReqValid(ctrlReqValid),
    .ctrlReqCode(ctrlReqCode), .ctrlRespData(ctrlRespData), .ctrlRespValid(ctrlRespValid),
    .cmdValid(cmdValid), .cmdBlock(cmdBlock), .cmdBlockLen(cmdBlockLen), .cmdLun(cmdLun),
    .cmdDirIn(cmdDirIn), .cmdLength(cmdLength), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
    .cmdDone(cmdDone), .cmdFailed(cmdFailed)
  );
  usb_host_model i_host (
    .clk(clk), .outData(outData), .outValid(outValid), .outLast(outLast),
    .outReady(outReady), .inData(inData), .inValid(inValid), .inLast(inLast),
    .inReady(inReady)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (cmdValid === 1'b1) nCmd <= nCmd + 1;
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [247:0] mk(input logic [31:0] t, l, input logic [7:0] f);
    return {128'h0f0e0d0c0b0a09080706050403020100, 8'h06, 8'h03, f, l, t, 32'h43425355};
  endfunction
  task automatic ctrl(input logic [7:0] c);
    ctrlReqValid <= 1'b1;
    ctrlReqCode <= c;
    @(posedge clk);
    ctrlReqValid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic xact(input logic d, input logic [31:0] len, input int k,
                      input logic f, input logic [7:0] st, input int stall);
    logic [247:0] dat;
    logic [103:0] exp;
    int           n0;
    int           m;
    n0 = nCmd;
    exp = {st, len - k, 32'h6a5b0000 + n0, 32'h53425355};
    for (int i = 0; i < 31; i++) dat[8*i+:8] = 8'h80 + 8'(i);
    @(posedge clk);
    i_host.send(mk(exp[63:32], len, {d, 7'h00}), 31);
    fork
      begin
        if (!d && len != 0) i_host.send(dat, k);
        i_host.recv();
      end
      begin
        if (stall != 0) begin
          repeat (stall) @(negedge clk);
          chk("outReady full", 0, outReady);
          @(posedge clk);
        end
        for (int i = 0; i < k; i++) begin
          txValid <= d;
          txData <= 8'ha0 + 8'(i);
          rxReady <= !d;
          @(negedge clk);
          while (!(d ? txReady : rxValid)) @(negedge clk);
          if (!d) chk("rxData", 8'h80 + i, rxData);
          @(posedge clk);
        end
        txValid <= 1'b0;
        rxReady <= 1'b0;
        cmdDone <= 1'b1;
        cmdFailed <= f;
        @(posedge clk);
        cmdDone <= 1'b0;
      end
    join
    m = i_host.got.size();
    chk("commands", n0 + 1, nCmd);
    chk("length", len, cmdLength);
    chk("dirIn", d, cmdDirIn);
    chk("lun", 3, cmdLun);
    chk("cbLen", 6, cmdBlockLen);
    chk("cbLow", 32'h03020100, cmdBlock[31:0]);
    chk("cbMid", 32'h00000504, cmdBlock[63:32]);
    chk("cbRest", 32'h0, cmdBlock[95:64] | cmdBlock[127:96]);
    chk("in bytes", (d ? k : 0) + 13, m);
    for (int i = 0; i < m - 13; i++) chk("data", 8'ha0 + i, i_host.got[i]);
    for (int i = 0; i < 13; i++) chk("status", exp[8*i+:8], i_host.got[m-13+i]);
  endtask
  task automatic s_ctrl();
    @(posedge clk);
    ctrl(8'hfe);
    chk("maxLun valid", 1, ctrlRespValid);
    chk("maxLun", 0, ctrlRespData);
    chk("protocol", 8'h50, protocolCode);
  endtask
  // Bad wrappers leave no trace; a reset before the data stage abandons the command
  task automatic s_refuse();
    int n0;
    n0 = nCmd;
    @(posedge clk);
    i_host.send(mk(1, 0, 8'h00) ^ 248'h1, 31);
    i_host.send(mk(2, 0, 8'h01), 31);
    i_host.send(mk(3, 0, 8'h00), 30);
    i_host.send(mk(4, 8, 8'h00), 31);
    ctrl(8'hff);
    chk("refused", n0 + 1, nCmd);
    chk("no status", 0, inValid);
  endtask
  task automatic s_zeroFail();
    xact(1'b1, 0, 0, 1'b1, 8'h01, 0);
  endtask
  task automatic s_outStall();
    xact(1'b0, 24, 24, 1'b0, 8'h00, 40);
  endtask
  task automatic s_inShort();
    i_host.slow = 2;
    xact(1'b1, 5, 3, 1'b0, 8'h00, 0);
    i_host.slow = 0;
  endtask
  task automatic s_phase();
    xact(1'b0, 8, 4, 1'b0, 8'h02, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    s_ctrl();
    s_refuse();
    s_zeroFail();
    s_outStall();
    s_inShort();
    s_phase();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule

/* bench/usb_host_model.sv */
// Purpose: host controller model on the bulk pipes
// Assumes: byte pipes, valid/ready taken on the rising edge
// Notes:   slow sets idle cycles before each bulk-in byte
`timescale 1ns/100ps
module usb_host_model (
  input  wire        clk,
  output logic [7:0] outData,
  output logic       outValid,
  output logic       outLast,
  input  wire        outReady,
  input  wire  [7:0] inData,
  input  wire        inValid,
  input  wire        inLast,
  output logic       inReady
);
  // ****
  // Packet tasks
  // ****
  int         slow = 0;
  logic [7:0] got[$];
  initial begin
    outData = 8'h00;
    outValid = 1'b0;
    outLast = 1'b0;
    inReady = 1'b0;
  end
  // One packet per call; last flags its final byte
  task automatic send(input logic [247:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      outData <= w[8*i+:8];
      outValid <= 1'b1;
      outLast <= (i == n - 1);
      @(negedge clk);
      while (!outReady) @(negedge clk);
      @(posedge clk);
    end
    outValid <= 1'b0;
    outLast <= 1'b0;
    // Released bus shows a changed value, not a stale byte
    outData <= ~w[8*n-8+:8];
  endtask
  task automatic recv();
    logic l;
    got.delete();
    do begin
      if (slow != 0) begin
        inReady <= 1'b0;
        repeat (slow) @(posedge clk);
      end
      inReady <= 1'b1;
      @(negedge clk);
      while (!inValid) @(negedge clk);
      got.push_back(inData);
      l = inLast;
      @(posedge clk);
    end while (!l);
    inReady <= 1'b0;
  endtask
endmodule

/* verilog/bot_consts.vh */
// Purpose: constants for the bulk-only storage transport framer
// Assumes: byte-wide endpoint streams, one clock
// Notes:   offsets are byte positions inside the wrappers
`ifndef BOT_CONSTS_VH
`define BOT_CONSTS_VH
`define PROTO_CODE        8'h50
`define CMD_WRAP_LEN      6'h1f
`define STAT_WRAP_LEN     4'hd
`define CMD_SIG           32'h43425355
`define STAT_SIG          32'h53425355
`define OFS_TAG           5'h04
`define OFS_LEN           5'h08
`define OFS_FLAGS         5'h0c
`define OFS_LUN           5'h0d
`define OFS_CBLEN         5'h0e
`define OFS_CB            5'h0f
`define OFS_STATUS        4'hc
`define DIR_BIT           7
`define ST_PASS           8'h00
`define ST_FAIL           8'h01
`define ST_PHASE          8'h02
`define REQ_RESET         8'hff
`define REQ_MAXLUN        8'hfe
`define MAX_LUN           8'h00
`define CB_MAX            5'h10
`define FIFO_DEPTH        16
`define FIFO_AW           4
`endif

/* verilog/bulk_only_storage_transport.v */
// Purpose: command/status wrapper framing and sequencing for bulk-only storage
// Assumes: byte streams for bulk-out and bulk-in with valid/ready; packet end
//          marked by a last flag; command engine answers with done and status
// Notes:   data stage bytes pass through a 16-word FIFO in either direction
`timescale 1ns/100ps
`include "bot_consts.vh"
module bulk_only_storage_transport (
  input  wire         clk,
  input  wire         nrst,
  output wire [7:0]   protocolCode,
  input  wire [7:0]   outData,
  input  wire         outValid,
  input  wire         outLast,
  output wire         outReady,
  output wire [7:0]   inData,
  output wire         inValid,
  output wire         inLast,
  input  wire         inReady,
  input  wire         ctrlReqValid,
  input  wire [7:0]   ctrlReqCode,
  output reg  [7:0]   ctrlRespData,
  output reg          ctrlRespValid,
  output reg          cmdValid,
  output reg  [127:0] cmdBlock,
  output reg  [4:0]   cmdBlockLen,
  output reg  [7:0]   cmdLun,
  output reg          cmdDirIn,
  output reg  [31:0]  cmdLength,
  output wire [7:0]   rxData,
  output wire         rxValid,
  input  wire         rxReady,
  input  wire [7:0]   txData,
  input  wire         txValid,
  output wire         txReady,
  input  wire         cmdDone,
  input  wire         cmdFailed
);
  // ****************************************
  // State machine
  // ****************************************
  localparam S_CMD    = 3'h0;
  localparam S_EXEC   = 3'h1;
  localparam S_DOUT   = 3'h2;
  localparam S_DIN    = 3'h3;
  localparam S_WAIT   = 3'h4;
  localparam S_STAT   = 3'h5;

  reg [2:0]   state_r;
  reg [4:0]   rxCnt_r;
  reg         badCmd_r;
  reg [31:0]  tag_r;
  reg [31:0]  sig_r;
  reg [7:0]   flags_r;
  reg [31:0]  done_r;
  reg [7:0]   status_r;
  reg [3:0]   txCnt_r;
  reg         engDone_r;
  reg         engFail_r;
  reg [127:0] cbBuf_r;
  reg [7:0]   status_nxt;
  wire [127:0] cbMask;
  wire        classReset;
  wire        outTake;
  wire        cmdEnd;
  wire [31:0] residue;
  wire        lenZero;

  assign protocolCode = `PROTO_CODE;
  assign classReset   = ctrlReqValid && (ctrlReqCode == `REQ_RESET);

  // Get status byte of a wrapper by position
  function [7:0] statByte;
    input [3:0]  pos;
    input [31:0] tagV;
    input [31:0] resV;
    input [7:0]  stV;
    reg   [31:0] word;
    begin
      case (pos[3:2])
        2'h0: word = `STAT_SIG;
        2'h1: word = tagV;
        2'h2: word = resV;
        default: word = {24'h0, stV};
      endcase
      word = word >> {pos[1:0], 3'b000};
      statByte = word[7:0];
    end
  endfunction

  // ****************************************
  // Command block mask
  // ****************************************
  // Bytes past the stated command length are zeroed, so a short command
  // never shows leftovers of an earlier, longer one
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gMask
      assign cbMask[8*g+:8] = (g < cmdBlockLen) ? 8'hff : 8'h00;
    end
  endgenerate

  // ****************************************
  // Wrapper byte maps
  // ****************************************
  // Command:  0-3 signature, 4-7 tag, 8-11 length, 12 flags,
  //           13 unit, 14 block length, 15-30 command block
  // Status:   0-3 signature, 4-7 tag, 8-11 residue, 12 status
  // Fields are little endian; the parser counts bytes rather than trusting
  // the last flag alone, so a short or long packet is dropped whole
  // Trade-off: dropped wrappers get no status; the host recovers with the
  // class reset, which also flushes the data FIFO

  // ****************************************
  // Status choice
  // ****************************************
  // An in stage that ends short is not a phase error: the residue tells it
  always @* begin
    if (engFail_r) begin
      status_nxt = `ST_FAIL;
    end else if (!lenZero && done_r != cmdLength && !dirIn) begin
      // Host sent fewer bytes than it announced
      status_nxt = `ST_PHASE;
    end else begin
      status_nxt = `ST_PASS;
    end
  end

  // ****************************************
  // Data stage FIFO
  // ****************************************
  wire       dirIn;
  wire [7:0] fIn;
  wire       fInValid;
  wire       fInReady;
  wire [7:0] fOut;
  wire       fOutValid;
  wire       fOutReady;
  wire       dataTake;
  wire       stageOut;
  wire       stageIn;

  assign dirIn    = flags_r[`DIR_BIT];
  assign stageOut = (state_r == S_DOUT);
  assign stageIn  = (state_r == S_DIN);
  assign fIn      = stageIn ? txData : outData;
  assign fInValid = stageIn ? txValid : (stageOut && outValid);
  assign txReady  = stageIn && fInReady;
  assign rxData   = fOut;
  assign rxValid  = stageOut && fOutValid;
  assign fOutReady = stageIn ? inReady : (stageOut && rxReady);
  assign dataTake = fOutValid && fOutReady && (stageIn || stageOut);

  // Flushed whenever the sequencer is idle, so bytes of an abandoned stage
  // never leak into the next command
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) uFifo (
    .clk      (clk),
    .nrst     (nrst),
    .flush    (classReset || (state_r == S_CMD)),
    .inData   (fIn),
    .inValid  (fInValid),
    .inReady  (fInReady),
    .outData  (fOut),
    .outValid (fOutValid),
    .outReady (fOutReady)
  );

  // ****************************************
  // Bulk ports
  // ****************************************
  assign outReady = (state_r == S_CMD) || (stageOut && fInReady);
  assign outTake  = outValid && (state_r == S_CMD);
  assign cmdEnd   = outTake && outLast;
  assign residue  = cmdLength - done_r;
  assign lenZero  = (cmdLength == 32'h0);
  assign inValid  = stageIn ? fOutValid : (state_r == S_STAT);
  assign inData   = stageIn ? fOut : statByte(txCnt_r, tag_r, residue, status_r);
  assign inLast   = (state_r == S_STAT) && (txCnt_r == `STAT_WRAP_LEN - 4'h1);

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clk) begin
    if (!nrst || classReset) begin
      state_r   <= S_CMD;
      rxCnt_r   <= 5'h0;
      badCmd_r  <= 1'b0;
      tag_r     <= 32'h0;
      sig_r     <= 32'h0;
      flags_r   <= 8'h0;
      done_r    <= 32'h0;
      status_r  <= `ST_PASS;
      txCnt_r   <= 4'h0;
      engDone_r <= 1'b0;
      engFail_r <= 1'b0;
      cmdValid  <= 1'b0;
      cmdBlock  <= 128'h0;
      cbBuf_r   <= 128'h0;
      cmdBlockLen <= 5'h0;
      cmdLun    <= 8'h0;
      cmdDirIn  <= 1'b0;
      cmdLength <= 32'h0;
    end else begin
      cmdValid <= 1'b0;
      // Completion is latched since it may come before the stage closes
      if (cmdDone && state_r != S_CMD) begin
        engDone_r <= 1'b1;
        engFail_r <= cmdFailed;
      end
      if (dataTake) begin
        done_r <= done_r + 32'h1;
      end
      case (state_r)
        S_CMD: begin
          if (outTake) begin
            rxCnt_r <= rxCnt_r + 5'h1;
            if (rxCnt_r > `CMD_WRAP_LEN - 6'h1) begin
              badCmd_r <= 1'b1;
            end
            if (rxCnt_r < `OFS_TAG) begin
              sig_r <= {outData, sig_r[31:8]};
            end else if (rxCnt_r < `OFS_LEN) begin
              tag_r <= {outData, tag_r[31:8]};
            end else if (rxCnt_r < `OFS_FLAGS) begin
              cmdLength <= {outData, cmdLength[31:8]};
            end else if (rxCnt_r == `OFS_FLAGS) begin
              flags_r <= outData;
            end else if (rxCnt_r == `OFS_LUN) begin
              cmdLun <= {4'h0, outData[3:0]};
            end else if (rxCnt_r == `OFS_CBLEN) begin
              cmdBlockLen <= (outData[4:0] > `CB_MAX) ? `CB_MAX : outData[4:0];
            end else begin
              cbBuf_r[{rxCnt_r[3:0] - 4'hf, 3'b000} +: 8] <= outData;
            end
          end
          if (cmdEnd) begin
            rxCnt_r <= 5'h0;
            badCmd_r <= 1'b0;
            // Invalid wrappers are dropped; host recovers with class reset
            if (!badCmd_r && rxCnt_r == `CMD_WRAP_LEN - 6'h1
                && sig_r == `CMD_SIG && flags_r[6:0] == 7'h0) begin
              state_r   <= S_EXEC;
              cmdValid  <= 1'b1;
              cmdDirIn  <= flags_r[`DIR_BIT];
              cmdBlock  <= cbBuf_r & cbMask;
              done_r    <= 32'h0;
              engDone_r <= 1'b0;
              engFail_r <= 1'b0;
              txCnt_r   <= 4'h0;
            end
          end
        end
        S_EXEC: begin
          if (lenZero) begin
            state_r <= S_WAIT;
          end else if (dirIn) begin
            state_r <= S_DIN;
          end else begin
            state_r <= S_DOUT;
          end
        end
        S_DOUT, S_DIN: begin
          // Stage closes at full length, or early when the engine gives up
          if ((dataTake && done_r + 32'h1 == cmdLength) || done_r == cmdLength) begin
            state_r <= S_WAIT;
          end else if (engDone_r && !fOutValid) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (engDone_r) begin
            state_r  <= S_STAT;
            status_r <= status_nxt;
          end
        end
        S_STAT: begin
          if (inReady) begin
            if (inLast) begin
              state_r <= S_CMD;
              txCnt_r <= 4'h0;
            end else begin
              txCnt_r <= txCnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= S_CMD;
        end
      endcase
    end
  end

  // ****************************************
  // Control endpoint class answer
  // ****************************************
  // Only the unit query answers here; the reset request acts in the sequencer
  always @(posedge clk) begin
    if (!nrst) begin
      ctrlRespData  <= 8'h0;
      ctrlRespValid <= 1'b0;
    end else begin
      ctrlRespValid <= ctrlReqValid && (ctrlReqCode == `REQ_MAXLUN);
      ctrlRespData  <= `MAX_LUN;
    end
  end
endmodule

/* verilog/byte_fifo.v */
// Purpose: small valid/ready FIFO for the data stage path
// Assumes: single clock, depth a power of two
// Notes:   full and empty come from a separate occupancy count
`timescale 1ns/100ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;
  wire            doWr;
  wire            doRd;

  // Depth is a power of two, so the top count bit alone marks full
  assign inReady  = ~count_r[AW];
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_r];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk) begin
    if (!nrst || flush) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doWr && !doRd) begin
        count_r <= count_r + 1'b1;
      end else if (doRd && !doWr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
